// ===== core/ppl_pkg.sv
// Package: addresses, field masks, reset values and operation codes shared by the
// port latch and pull-up selection logic. Assumes an 8-bit processor data path.
package ppl_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 16;

    // Port output latch addresses
    localparam logic [15:0] ADDR_PORT0  = 16'hFF00;
    localparam logic [15:0] ADDR_PORT2  = 16'hFF02;
    localparam logic [15:0] ADDR_PORT3  = 16'hFF03;
    localparam logic [15:0] ADDR_PORT4  = 16'hFF04;
    localparam logic [15:0] ADDR_PORT12 = 16'hFF0C;

    // Pull-up selection register addresses
    localparam logic [15:0] ADDR_PULLUP_SELECT_PORT0  = 16'hFF30;
    localparam logic [15:0] ADDR_PULLUP_SELECT_PORT2  = 16'hFF32;
    localparam logic [15:0] ADDR_PULLUP_SELECT_PORT3  = 16'hFF33;
    localparam logic [15:0] ADDR_PULLUP_SELECT_PORT4  = 16'hFF34;
    localparam logic [15:0] ADDR_PULLUP_SELECT_PORT12 = 16'hFF3C;

    // Implemented pin_pullup_bit positions
    localparam logic [7:0] MASK_PULLUP_PORT0  = 8'h0F;
    localparam logic [7:0] MASK_PULLUP_PORT2  = 8'h0F;
    localparam logic [7:0] MASK_PULLUP_PORT3  = 8'h0F;
    localparam logic [7:0] MASK_PULLUP_PORT4  = 8'hFF;
    localparam logic [7:0] MASK_PULLUP_PORT12 = 8'h09;

    localparam logic [7:0] RESET_PULLUP = 8'h00;
    localparam logic [7:0] RESET_LATCH  = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Memory manipulation operations
    typedef enum logic [1:0] {
        PPL_OP_MOV = 2'b00,
        PPL_OP_AND = 2'b01,
        PPL_OP_OR  = 2'b10,
        PPL_OP_XOR = 2'b11
    } ppl_op_t;

endpackage : ppl_pkg

// ===== core/ppl_port_latch.sv
// One port's output latch, output enable and read-back selection.
// Assumes mode is 1 for input, 0 for output, per pin, from the port mode register.
`timescale 1ns/100ps
module ppl_port_latch #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [WIDTH-1:0] mode_in,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] latch_q,
    output logic      [WIDTH-1:0] oe_q,
    output logic      [WIDTH-1:0] readback
);

    initial
    begin
        if (WIDTH < 1 || WIDTH > 8)
            $error("ppl_port_latch: WIDTH must be 1..8");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Latch written in either mode, driven only in output mode
    always_ff @(posedge mclk)
    begin
        if (reset)
            latch_q <= ppl_pkg::RESET_LATCH[WIDTH-1:0];
        else if (wr_en)
            latch_q <= wdata;
    end

    // Registered so the pin driver comes straight from a flop
    always_ff @(posedge mclk)
    begin
        if (reset)
            oe_q <= '0;
        else
            oe_q <= ~mode_in;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output pins read the latch, input pins read the pin level
    assign readback = (mode_in & pin_in) | (~mode_in & latch_q);

endmodule : ppl_port_latch

// ===== core/ppl_pullup_reg.sv
// One pull-up selection register with a fixed mask of implemented bits.
// Assumes the caller has already merged single-bit updates into a whole byte.
`timescale 1ns/100ps
module ppl_pullup_reg #(
    parameter logic [7:0] IMPL_MASK = 8'hFF
) (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    output logic      [7:0] q
);

    initial
    begin
        if (IMPL_MASK == 8'h00)
            $error("ppl_pullup_reg: IMPL_MASK must hold at least one bit");
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            q <= ppl_pkg::RESET_PULLUP;
        else if (wr_en)
            q <= wdata & IMPL_MASK;
    end

endmodule : ppl_pullup_reg

// ===== core/ppl_port_pullup.sv
// Top: port output latches and pull-up selection for ports 0, 2, 3, 4 and 12.
// Assumes the processor issues one access per cycle and supplies port mode bits.
`timescale 1ns/100ps
// Overview of operation
// - Pull-up bit one connects pin pull-up
// - Pull-ups only on ports 0,2,3,4,12 listed bits
// - Reset clears all pull-up registers
// - Pull-up registers take bit and byte accesses
// - Port4 pull-up full byte, port12 bits 3,0
// - Bit manipulation performed as whole-byte access
// - Output mode write drives latch onto pin
// - Input mode write updates latch only
// - Reset clears every output latch
// - Output mode read returns latch content
// - Input mode read returns pin level
// - Output mode operation uses and updates latch
// - Input mode operation uses pin, stores latch
// - Latch zero drives low, one high
module ppl_port_pullup (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    input  wire logic [7:0]  cpu_wdata,
    input  wire logic        cpu_bit_en,
    input  wire logic [2:0]  cpu_bit_sel,
    input  wire logic [1:0]  cpu_op,
    output logic      [7:0]  cpu_rdata,
    input  wire logic [7:0]  port0_mode,
    input  wire logic [7:0]  port2_mode,
    input  wire logic [7:0]  port3_mode,
    input  wire logic [7:0]  port4_mode,
    input  wire logic [7:0]  port12_mode,
    input  wire logic [7:0]  port0_pin_in,
    input  wire logic [7:0]  port2_pin_in,
    input  wire logic [7:0]  port3_pin_in,
    input  wire logic [7:0]  port4_pin_in,
    input  wire logic [7:0]  port12_pin_in,
    output logic      [7:0]  port0_pin_out,
    output logic      [7:0]  port2_pin_out,
    output logic      [7:0]  port3_pin_out,
    output logic      [7:0]  port4_pin_out,
    output logic      [7:0]  port12_pin_out,
    output logic      [7:0]  port0_pin_oe,
    output logic      [7:0]  port2_pin_oe,
    output logic      [7:0]  port3_pin_oe,
    output logic      [7:0]  port4_pin_oe,
    output logic      [7:0]  port12_pin_oe,
    output logic      [7:0]  port0_pullup_en,
    output logic      [7:0]  port2_pullup_en,
    output logic      [7:0]  port3_pullup_en,
    output logic      [7:0]  port4_pullup_en,
    output logic      [7:0]  port12_pullup_en
);

    logic [7:0] rb_p0;
    logic [7:0] rb_p2;
    logic [7:0] rb_p3;
    logic [7:0] rb_p4;
    logic [7:0] rb_p12;
    logic [7:0] cur_val;
    logic [7:0] nxt_val;
    logic [7:0] bit_mask;
    logic [7:0] rdata_ff;
    logic       wr_p0;
    logic       wr_p2;
    logic       wr_p3;
    logic       wr_p4;
    logic       wr_p12;
    logic       wr_pu0;
    logic       wr_pu2;
    logic       wr_pu3;
    logic       wr_pu4;
    logic       wr_pullup_select_port12;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode; an unmapped address selects nothing
    always_comb
    begin
        wr_p0   = 1'b0;
        wr_p2   = 1'b0;
        wr_p3   = 1'b0;
        wr_p4   = 1'b0;
        wr_p12  = 1'b0;
        wr_pu0  = 1'b0;
        wr_pu2  = 1'b0;
        wr_pu3  = 1'b0;
        wr_pu4  = 1'b0;
        wr_pullup_select_port12 = 1'b0;
        if (cpu_wr)
        begin
            case (cpu_addr)
                ppl_pkg::ADDR_PORT0:                wr_p0   = 1'b1;
                ppl_pkg::ADDR_PORT2:                wr_p2   = 1'b1;
                ppl_pkg::ADDR_PORT3:                wr_p3   = 1'b1;
                ppl_pkg::ADDR_PORT4:                wr_p4   = 1'b1;
                ppl_pkg::ADDR_PORT12:               wr_p12  = 1'b1;
                ppl_pkg::ADDR_PULLUP_SELECT_PORT0:  wr_pu0  = 1'b1;
                ppl_pkg::ADDR_PULLUP_SELECT_PORT2:  wr_pu2  = 1'b1;
                ppl_pkg::ADDR_PULLUP_SELECT_PORT3:  wr_pu3  = 1'b1;
                ppl_pkg::ADDR_PULLUP_SELECT_PORT4:  wr_pu4  = 1'b1;
                ppl_pkg::ADDR_PULLUP_SELECT_PORT12: wr_pullup_select_port12 = 1'b1;
                default:                            wr_p0   = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Current byte seen by a read or by the first half of a modify
    always_comb
    begin
        case (cpu_addr)
            ppl_pkg::ADDR_PORT0:  cur_val = rb_p0;
            ppl_pkg::ADDR_PORT2:  cur_val = rb_p2;
            ppl_pkg::ADDR_PORT3:  cur_val = rb_p3;
            ppl_pkg::ADDR_PORT4:  cur_val = rb_p4;
            ppl_pkg::ADDR_PORT12: cur_val = rb_p12;
            ppl_pkg::ADDR_PULLUP_SELECT_PORT0:  cur_val = port0_pullup_en;
            ppl_pkg::ADDR_PULLUP_SELECT_PORT2:  cur_val = port2_pullup_en;
            ppl_pkg::ADDR_PULLUP_SELECT_PORT3:  cur_val = port3_pullup_en;
            ppl_pkg::ADDR_PULLUP_SELECT_PORT4:  cur_val = port4_pullup_en;
            ppl_pkg::ADDR_PULLUP_SELECT_PORT12: cur_val = port12_pullup_en;
            default: cur_val = ppl_pkg::READ_UNMAPPED;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Byte and bit operations all end as one whole-byte write.
    // Input pins in a mixed port therefore pick up their pin level, except on a byte move.
    assign bit_mask = 8'h01 << cpu_bit_sel;

    always_comb
    begin
        nxt_val = cur_val;
        case (ppl_pkg::ppl_op_t'(cpu_op))
            ppl_pkg::PPL_OP_MOV:
            begin
                if (cpu_bit_en)
                    nxt_val = cpu_wdata[0] ? (cur_val | bit_mask)
                                           : (cur_val & ~bit_mask);
                else
                    nxt_val = cpu_wdata;
            end
            ppl_pkg::PPL_OP_AND:
            begin
                if (cpu_bit_en)
                    nxt_val = cpu_wdata[0] ? cur_val : (cur_val & ~bit_mask);
                else
                    nxt_val = cur_val & cpu_wdata;
            end
            ppl_pkg::PPL_OP_OR:
            begin
                if (cpu_bit_en)
                    nxt_val = cpu_wdata[0] ? (cur_val | bit_mask) : cur_val;
                else
                    nxt_val = cur_val | cpu_wdata;
            end
            ppl_pkg::PPL_OP_XOR:
            begin
                if (cpu_bit_en)
                    nxt_val = cpu_wdata[0] ? (cur_val ^ bit_mask) : cur_val;
                else
                    nxt_val = cur_val ^ cpu_wdata;
            end
            default:
            begin
                nxt_val = cur_val;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data held until the next read
    always_ff @(posedge mclk)
    begin
        if (reset)
            rdata_ff <= ppl_pkg::READ_UNMAPPED;
        else if (cpu_rd)
            rdata_ff <= cur_val;
    end

    assign cpu_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Port output latches
    ppl_port_latch #(
        .WIDTH (8)
    ) u_latch_p0 (
        .mclk     (mclk),
        .reset    (reset),
        .wr_en    (wr_p0),
        .wdata    (nxt_val),
        .mode_in  (port0_mode),
        .pin_in   (port0_pin_in),
        .latch_q  (port0_pin_out),
        .oe_q     (port0_pin_oe),
        .readback (rb_p0)
    );

    ppl_port_latch #(
        .WIDTH (8)
    ) u_latch_p2 (
        .mclk     (mclk),
        .reset    (reset),
        .wr_en    (wr_p2),
        .wdata    (nxt_val),
        .mode_in  (port2_mode),
        .pin_in   (port2_pin_in),
        .latch_q  (port2_pin_out),
        .oe_q     (port2_pin_oe),
        .readback (rb_p2)
    );

    ppl_port_latch #(
        .WIDTH (8)
    ) u_latch_p3 (
        .mclk     (mclk),
        .reset    (reset),
        .wr_en    (wr_p3),
        .wdata    (nxt_val),
        .mode_in  (port3_mode),
        .pin_in   (port3_pin_in),
        .latch_q  (port3_pin_out),
        .oe_q     (port3_pin_oe),
        .readback (rb_p3)
    );

    ppl_port_latch #(
        .WIDTH (8)
    ) u_latch_p4 (
        .mclk     (mclk),
        .reset    (reset),
        .wr_en    (wr_p4),
        .wdata    (nxt_val),
        .mode_in  (port4_mode),
        .pin_in   (port4_pin_in),
        .latch_q  (port4_pin_out),
        .oe_q     (port4_pin_oe),
        .readback (rb_p4)
    );

    ppl_port_latch #(
        .WIDTH (8)
    ) u_latch_p12 (
        .mclk     (mclk),
        .reset    (reset),
        .wr_en    (wr_p12),
        .wdata    (nxt_val),
        .mode_in  (port12_mode),
        .pin_in   (port12_pin_in),
        .latch_q  (port12_pin_out),
        .oe_q     (port12_pin_oe),
        .readback (rb_p12)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pull-up selection; masks fix which pins can ever be pulled up
    ppl_pullup_reg #(
        .IMPL_MASK (ppl_pkg::MASK_PULLUP_PORT0)
    ) u_pu_p0 (
        .mclk  (mclk),
        .reset (reset),
        .wr_en (wr_pu0),
        .wdata (nxt_val),
        .q     (port0_pullup_en)
    );

    ppl_pullup_reg #(
        .IMPL_MASK (ppl_pkg::MASK_PULLUP_PORT2)
    ) u_pu_p2 (
        .mclk  (mclk),
        .reset (reset),
        .wr_en (wr_pu2),
        .wdata (nxt_val),
        .q     (port2_pullup_en)
    );

    ppl_pullup_reg #(
        .IMPL_MASK (ppl_pkg::MASK_PULLUP_PORT3)
    ) u_pu_p3 (
        .mclk  (mclk),
        .reset (reset),
        .wr_en (wr_pu3),
        .wdata (nxt_val),
        .q     (port3_pullup_en)
    );

    ppl_pullup_reg #(
        .IMPL_MASK (ppl_pkg::MASK_PULLUP_PORT4)
    ) u_pu_p4 (
        .mclk  (mclk),
        .reset (reset),
        .wr_en (wr_pu4),
        .wdata (nxt_val),
        .q     (port4_pullup_en)
    );

    ppl_pullup_reg #(
        .IMPL_MASK (ppl_pkg::MASK_PULLUP_PORT12)
    ) u_pu_p12 (
        .mclk  (mclk),
        .reset (reset),
        .wr_en (wr_pullup_select_port12),
        .wdata (nxt_val),
        .q     (port12_pullup_en)
    );

endmodule : ppl_port_pullup

// ===== verification/ppl_port_pullup_properties.sv
// Checker: latch, enable and pull-up properties on the top ports.
// Assumes the single mclk domain and synchronous active-high reset.
`timescale 1ns/100ps
module ppl_port_pullup_checker (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic [15:0] cpu_addr,
    input wire logic        cpu_wr,
    input wire logic        cpu_rd,
    input wire logic [7:0]  cpu_wdata,
    input wire logic        cpu_bit_en,
    input wire logic [1:0]  cpu_op,
    input wire logic [7:0]  cpu_rdata,
    input wire logic [7:0]  port2_mode,
    input wire logic [7:0]  port4_mode,
    input wire logic [7:0]  port2_pin_in,
    input wire logic [7:0]  port4_pin_in,
    input wire logic [7:0]  port2_pin_out,
    input wire logic [7:0]  port4_pin_out,
    input wire logic [7:0]  port4_pin_oe,
    input wire logic [7:0]  port0_pullup_en,
    input wire logic [7:0]  port4_pullup_en,
    input wire logic [7:0]  port12_pullup_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic bw;
    assign bw = cpu_wr && !cpu_bit_en;
    a_latch_reset: assert property (disable iff (1'b0) reset |=> port4_pin_out == 8'h00)
        else $error("latch not cleared by reset");
    a_pullup_reset: assert property (disable iff (1'b0) reset |=>
        (port0_pullup_en | port4_pullup_en | port12_pullup_en) == 8'h00)
        else $error("pull-up not cleared by reset");
    a_pullup_mask: assert property (((port12_pullup_en & 8'hF6) |
        (port0_pullup_en & 8'hF0)) == 8'h00) else $error("unimplemented pull-up bit set");
    a_oe_follows_mode: assert property (!reset |=> port4_pin_oe == ~$past(port4_mode))
        else $error("output enable does not follow mode");
    a_byte_move: assert property (bw && cpu_addr == 16'hFF04 && cpu_op == 2'h0
        |=> port4_pin_out == $past(cpu_wdata)) else $error("byte write not on pin");
    a_pullup_write: assert property (bw && cpu_addr == 16'hFF34 && cpu_op == 2'h0
        |=> port4_pullup_en == $past(cpu_wdata)) else $error("pull-up write lost");
    a_latch_hold: assert property (!(cpu_wr && cpu_addr == 16'hFF04)
        |=> $stable(port4_pin_out)) else $error("latch changed without write");
    a_read_latch: assert property (cpu_rd && cpu_addr == 16'hFF04 && port4_mode == 8'h00
        |=> cpu_rdata == $past(port4_pin_out)) else $error("output read not latch");
    a_read_pin: assert property (cpu_rd && cpu_addr == 16'hFF04 && port4_mode == 8'hFF
        |=> cpu_rdata == $past(port4_pin_in)) else $error("input read not pin");
    a_output_op: assert property (bw && cpu_addr == 16'hFF04 && cpu_op == 2'h3
        && port4_mode == 8'h00 |=> port4_pin_out == ($past(port4_pin_out) ^ $past(cpu_wdata)))
        else $error("output op wrong");
    a_input_op: assert property (bw && cpu_addr == 16'hFF02 && cpu_op == 2'h2
        && port2_mode == 8'hFF |=> port2_pin_out == ($past(port2_pin_in) | $past(cpu_wdata)))
        else $error("input op wrong");
    c_pullup12: cover property (cpu_wr && cpu_addr == 16'hFF3C);
    c_bit_op: cover property (cpu_wr && cpu_bit_en);
    c_read_pin: cover property (cpu_rd && port4_mode == 8'hFF);
endmodule : ppl_port_pullup_checker
bind ppl_port_pullup ppl_port_pullup_checker u_checker (.*);

// ===== verification/ppl_pin_model.sv
// Pins and board: driver, board source, pull-up or floating.
// Assumes ports packed as {p12,p4,p3,p2,p0}, bit 0 of port 0 lowest.
`timescale 1ns/100ps
module ppl_pin_model (
    input wire logic        mclk,
    input wire logic [39:0] pin_out,
    input wire logic [39:0] pin_oe,
    input wire logic [39:0] pullup_en,
    input wire logic [39:0] board_val,
    input wire logic [39:0] board_en,
    output logic     [39:0] pin_level
);
    logic [39:0] float_ff = 40'h0;
    // Floating pins toggle so a stale value never passes
    always_ff @(posedge mclk)
        float_ff <= ~float_ff;
    always_comb
        for (int i = 0; i < 40; i++)
            if (pin_oe[i])
                pin_level[i] = pin_out[i];
            else if (board_en[i])
                pin_level[i] = board_val[i];
            else if (pullup_en[i])
                pin_level[i] = 1'b1;
            else
                pin_level[i] = float_ff[i];
endmodule : ppl_pin_model

// ===== verification/ppl_port_pullup_bench.sv
// Bench: register, latch and pin scenarios for the port block.
// Assumes the pin model drives every pin_in from the outputs, board source, pull-up or float.
`timescale 1ns/100ps
module ppl_port_pullup_bench;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic [15:0] cpu_addr = 16'h0000;
    logic        cpu_wr = 1'b0, cpu_rd = 1'b0, cpu_bit_en = 1'b0;
    logic [7:0]  cpu_wdata = 8'h00;
    logic [2:0]  cpu_bit_sel = 3'h0;
    logic [1:0]  cpu_op = 2'h0;
    logic [7:0]  port0_mode = 8'hFF, port2_mode = 8'hFF, port3_mode = 8'hFF;
    logic [7:0]  port4_mode = 8'hFF, port12_mode = 8'hFF;
    logic [39:0] board_val = 40'h0, board_en = 40'h0;
    wire logic [7:0] port0_pin_in, port2_pin_in, port3_pin_in, port4_pin_in, port12_pin_in;
    logic [7:0]  cpu_rdata, port0_pin_out, port2_pin_out, port3_pin_out, port4_pin_out;
    logic [7:0]  port12_pin_out, port0_pin_oe, port2_pin_oe, port3_pin_oe, port4_pin_oe;
    logic [7:0]  port12_pin_oe, port0_pullup_en, port2_pullup_en, port3_pullup_en;
    logic [7:0]  port4_pullup_en, port12_pullup_en;
    logic [15:0] pu_a [5] = '{16'hFF30, 16'hFF32, 16'hFF33, 16'hFF34, 16'hFF3C};
    logic [7:0]  pu_m [5] = '{8'h0F, 8'h0F, 8'h0F, 8'hFF, 8'h09};
    logic [39:0] pu_en;
    int          errors = 0, n_compared = 0;
    always #2 mclk = ~mclk;
    assign pu_en = {port12_pullup_en, port4_pullup_en, port3_pullup_en, port2_pullup_en,
                    port0_pullup_en};
    ppl_port_pullup u_dut (.*);
    ppl_pin_model u_pins (
        .mclk      (mclk),
        .pin_out   ({port12_pin_out, port4_pin_out, port3_pin_out, port2_pin_out, port0_pin_out}),
        .pin_oe    ({port12_pin_oe, port4_pin_oe, port3_pin_oe, port2_pin_oe, port0_pin_oe}),
        .pullup_en (pu_en),
        .board_val (board_val),
        .board_en  (board_en),
        .pin_level ({port12_pin_in, port4_pin_in, port3_pin_in, port2_pin_in, port0_pin_in})
    );
    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    // One access per call; a gap cycle keeps strobes single-driven
    task automatic access(input logic [15:0] a, input logic w, input logic [1:0] op,
                          input logic b, input logic [2:0] sel, input logic [7:0] d);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_wr <= w;
        cpu_rd <= !w;
        cpu_op <= op;
        cpu_bit_en <= b;
        cpu_bit_sel <= sel;
        cpu_wdata <= d;
        @(posedge mclk);
        cpu_wr <= 1'b0;
        cpu_rd <= 1'b0;
        #1;
    endtask : access
    task automatic rd_chk(input string n, input logic [15:0] a, input logic [7:0] exp);
        access(a, 1'b0, 2'h0, 1'b0, 3'h0, 8'h00);
        check(n, cpu_rdata, exp);
    endtask : rd_chk
    task automatic s_reset;
        foreach (pu_a[i]) rd_chk("pullup reset", pu_a[i], 8'h00);
        check("latch reset", port4_pin_out, 8'h00);
    endtask : s_reset
    task automatic s_pullup;
        foreach (pu_a[i])
        begin
            access(pu_a[i], 1'b1, 2'h0, 1'b0, 3'h0, 8'hFF);
            rd_chk("pullup read", pu_a[i], pu_m[i]);
            check("pullup pin", pu_en[8*i +: 8], pu_m[i]);
        end
        rd_chk("pulled input", 16'hFF04, 8'hFF);
        access(16'hFF3C, 1'b1, 2'h0, 1'b1, 3'h3, 8'h00);
        check("pullup bit clear", port12_pullup_en, 8'h01);
        access(16'hFF3C, 1'b1, 2'h2, 1'b1, 3'h3, 8'h01);
        rd_chk("pullup bit set", 16'hFF3C, 8'h09);
        access(16'hFF31, 1'b1, 2'h0, 1'b0, 3'h0, 8'hFF);
        rd_chk("unmapped", 16'hFF31, 8'h00);
    endtask : s_pullup
    task automatic s_output;
        @(posedge mclk);
        port0_mode <= 8'h00;
        port4_mode <= 8'h00;
        port12_mode <= 8'h00;
        access(16'hFF04, 1'b1, 2'h0, 1'b0, 3'h0, 8'hA5);
        check("out pin", port4_pin_out, 8'hA5);
        check("out enable", port4_pin_oe, 8'hFF);
        rd_chk("out read", 16'hFF04, 8'hA5);
        access(16'hFF04, 1'b1, 2'h3, 1'b0, 3'h0, 8'h0F);
        rd_chk("out op", 16'hFF04, 8'hAA);
        access(16'hFF04, 1'b1, 2'h1, 1'b0, 3'h0, 8'hF0);
        check("out and", port4_pin_out, 8'hA0);
        access(16'hFF04, 1'b1, 2'h3, 1'b1, 3'h0, 8'h01);
        check("out bit xor", port4_pin_out, 8'hA1);
        access(16'hFF04, 1'b1, 2'h1, 1'b1, 3'h7, 8'h00);
        check("out bit and", port4_pin_out, 8'h21);
        access(16'hFF00, 1'b1, 2'h0, 1'b0, 3'h0, 8'h3C);
        check("port0 pin", port0_pin_out, 8'h3C);
        check("port0 enable", port0_pin_oe, 8'hFF);
        access(16'hFF0C, 1'b1, 2'h0, 1'b0, 3'h0, 8'h09);
        check("port12 pin", port12_pin_out, 8'h09);
        check("port12 enable", port12_pin_oe, 8'hFF);
    endtask : s_output
    task automatic s_input;
        @(posedge mclk);
        board_en[15:8] <= 8'hFF;
        board_val[15:8] <= 8'h30;
        access(16'hFF02, 1'b1, 2'h0, 1'b0, 3'h0, 8'h5A);
        check("in latch", port2_pin_out, 8'h5A);
        check("in enable", port2_pin_oe, 8'h00);
        rd_chk("in read", 16'hFF02, 8'h30);
        access(16'hFF02, 1'b1, 2'h2, 1'b0, 3'h0, 8'h0F);
        check("in op", port2_pin_out, 8'h3F);
    endtask : s_input
    task automatic s_mixed;
        @(posedge mclk);
        port3_mode <= 8'hF0;
        board_en[23:16] <= 8'hF0;
        board_val[23:16] <= 8'hF0;
        access(16'hFF03, 1'b1, 2'h0, 1'b0, 3'h0, 8'h00);
        access(16'hFF03, 1'b1, 2'h2, 1'b1, 3'h0, 8'h01);
        check("mixed bit op", port3_pin_out, 8'hF1);
        check("mixed enable", port3_pin_oe, 8'h0F);
    endtask : s_mixed
    task automatic s_reset_mid;
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        #1;
        check("latch reset mid", port4_pin_out, 8'h00);
        check("pullup reset mid", port12_pullup_en, 8'h00);
        check("port0 reset mid", port0_pin_out, 8'h00);
        check("enable reset mid", port4_pin_oe, 8'h00);
        check("mixed enable reset", port3_pin_oe, 8'h00);
        check("rdata reset mid", cpu_rdata, 8'h00);
        rd_chk("pullup after reset", 16'hFF34, 8'h00);
    endtask : s_reset_mid
    task automatic stop_test;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        s_reset();
        s_pullup();
        s_output();
        s_input();
        s_mixed();
        s_reset_mid();
        stop_test();
    end
    // Whole run is under 200 cycles
    initial
    begin
        repeat (2000) @(posedge mclk);
        errors++;
        stop_test();
    end
endmodule : ppl_port_pullup_bench
